/* src/sto_pkg.sv */
// constants, register map, states and stop-sequence decoding for the torque-off supervisor
package sto_pkg;
  // clock and timing figures
  localparam int CLK_FREQ_KHZ      = 50000;  // mclk rate, 50 MHz
  localparam int PULSE_IGNORE_US   = 1000;   // off pulses shorter than this are ignored
  localparam int FILTER_TIME_US    = 2000;   // channel must stay changed this long
  localparam int MONITOR_MAX_US    = 6000;   // monitor must follow channels within this
  localparam int TORQUE_OFF_MAX_US = 5000;   // torque must be gone within this
  localparam int FILTER_CYCLES     = FILTER_TIME_US * CLK_FREQ_KHZ / 1000;
  localparam int MS_CYCLES         = CLK_FREQ_KHZ;  // cycles in one millisecond
  localparam int CNT_W             = 17;     // wide enough for FILTER_CYCLES and MS_CYCLES
  localparam logic FILT_RST        = 1'b1;   // channels assumed active out of reset

  // register bus
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] ADDR_BRAKE_DELAY = 8'h00;  // brake_delay_running_param, ms
  localparam logic [ADDR_W-1:0] ADDR_SPEED_THR   = 8'h04;  // brake_speed_threshold_param
  localparam logic [ADDR_W-1:0] ADDR_STOP_SEQ    = 8'h08;  // both stop sequence settings
  localparam logic [ADDR_W-1:0] ADDR_STATUS      = 8'h0c;  // read-only state
  localparam logic [ADDR_W-1:0] ADDR_ERROR       = 8'h10;  // read-only error code

  // field layout
  localparam int SEQ_W        = 3;
  localparam int ALM_SEQ_LSB  = 0;   // alarm_stop_sequence_param
  localparam int SOFF_SEQ_LSB = 4;   // servo_off_stop_sequence_param
  localparam int ST_CUTOFF_B  = 0;
  localparam int ST_MONITOR_B = 1;
  localparam int ST_CHA_B     = 2;
  localparam int ST_CHB_B     = 3;
  localparam int ST_RETERR_B  = 4;
  localparam int ST_CLRERR_B  = 5;
  localparam int ST_READY_B   = 6;
  localparam int ST_BRAKE_B   = 7;
  localparam int ST_DB_B      = 8;

  // reset values
  localparam logic [15:0]      BRAKE_DELAY_RST = 16'h0032;
  localparam logic [15:0]      SPEED_THR_RST   = 16'h001e;
  localparam logic [SEQ_W-1:0] SEQ_RST         = 3'h0;

  // error codes shown on the display
  localparam logic [7:0] ERR_NONE   = 8'h00;
  localparam logic [7:0] ERR_CUTOFF = 8'h1e;
  localparam logic [7:0] ERR_RETURN = 8'h1f;
  localparam logic [7:0] ERR_CLEAR  = 8'h20;

  // stop sequence codes: braking while decelerating / once stopped
  localparam logic [SEQ_W-1:0] SEQ_DB_DB     = 3'h0;
  localparam logic [SEQ_W-1:0] SEQ_FREE_DB   = 3'h1;
  localparam logic [SEQ_W-1:0] SEQ_DB_FREE   = 3'h2;
  localparam logic [SEQ_W-1:0] SEQ_FREE_FREE = 3'h3;

  typedef enum logic [1:0] {
    ST_NORMAL = 2'b01,
    ST_CUTOFF = 2'b10
  } sup_state_t;

  // dynamic brake demand for a sequence code; unknown codes brake, the safe side
  function automatic logic db_for_seq(input logic [SEQ_W-1:0] seq, input logic stopped);
    logic db;
    db = 1'b1;
    case (seq)
      SEQ_DB_DB:     db = 1'b1;
      SEQ_FREE_DB:   db = stopped;
      SEQ_DB_FREE:   db = ~stopped;
      SEQ_FREE_FREE: db = 1'b0;
      default:       db = 1'b1;
    endcase
    return db;
  endfunction
endpackage

/* src/chan_filter.sv */
// two-stage synchroniser and glitch filter for one safety channel
`timescale 1ns/1ps
`default_nettype none
module chan_filter #(
  parameter int FILT_CYCLES = sto_pkg::FILTER_CYCLES
) (
  input  wire logic mclk,
  input  wire logic reset,
  input  wire logic raw_in,    // channel pin, high while active
  output logic      filt_out   // filtered channel level
);
  import sto_pkg::*;

  logic             sync1_reg;  // first stage, read only by the second
  logic             sync2_reg;
  logic             filt_reg;
  logic             filt_next;
  logic [CNT_W-1:0] cnt_reg;    // cycles the synced level has differed
  logic [CNT_W-1:0] cnt_next;

  // a level must hold for the full filter time, so short self-test pulses vanish
  always_comb begin
    filt_next = filt_reg;
    cnt_next  = '0;
    if (sync2_reg != filt_reg) begin
      if (cnt_reg == CNT_W'(FILT_CYCLES - 1)) begin
        filt_next = sync2_reg;
      end else begin
        cnt_next = cnt_reg + CNT_W'(1);
      end
    end
  end

  // registers only
  always_ff @(posedge mclk) begin
    if (reset) begin
      sync1_reg <= FILT_RST;
      sync2_reg <= FILT_RST;
      filt_reg  <= FILT_RST;
      cnt_reg   <= '0;
    end else begin
      sync1_reg <= raw_in;
      sync2_reg <= sync1_reg;
      filt_reg  <= filt_next;
      cnt_reg   <= cnt_next;
    end
  end

  assign filt_out = filt_reg;

  // the filtered level only moves after the synced level held for the full count
  filter_hold_a: assert property (@(posedge mclk) disable iff (reset)
    (!$past(reset) && $changed(filt_reg)) |->
      ($past(cnt_reg) == CNT_W'(FILT_CYCLES - 1) && filt_reg == $past(sync2_reg)))
    else $error("filtered channel changed before the filter time");
endmodule
`default_nettype wire

/* src/brake_seq.sv */
// holding-brake release timing for the torque-off entry
`timescale 1ns/1ps
`default_nettype none
module brake_seq #(
  parameter int MS_CYC = sto_pkg::MS_CYCLES
) (
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        hold_release,  // drive is running with torque
  input  wire logic        cutoff_start,  // one-cycle pulse on entering torque-off
  input  wire logic        speed_low,     // speed under the brake threshold
  input  wire logic [15:0] delay_ms,      // brake delay at running
  output logic             brake_release  // high keeps the brake released
);
  import sto_pkg::*;

  logic             rel_reg;
  logic             rel_next;
  logic             act_reg;   // delay running
  logic             act_next;
  logic [CNT_W-1:0] pre_reg;   // millisecond prescaler
  logic [CNT_W-1:0] pre_next;
  logic [15:0]      ms_reg;    // elapsed milliseconds
  logic [15:0]      ms_next;

  // release while running; on torque-off wait for delay or low speed, first wins
  always_comb begin
    rel_next = rel_reg;
    act_next = act_reg;
    pre_next = '0;
    ms_next  = '0;
    if (hold_release) begin
      rel_next = 1'b1;
      act_next = 1'b0;
    end else if (cutoff_start && rel_reg && !act_reg) begin
      act_next = 1'b1;
    end else if (act_reg) begin
      pre_next = pre_reg + CNT_W'(1);
      ms_next  = ms_reg;
      if (pre_reg == CNT_W'(MS_CYC - 1)) begin
        pre_next = '0;
        ms_next  = ms_reg + 16'h0001;
      end
      if (speed_low || ms_reg >= delay_ms) begin
        rel_next = 1'b0;
        act_next = 1'b0;
      end
    end else begin
      rel_next = 1'b0;  // ordinary servo-off engages at once
    end
  end

  // registers only
  always_ff @(posedge mclk) begin
    if (reset) begin
      rel_reg <= 1'b0;
      act_reg <= 1'b0;
      pre_reg <= '0;
      ms_reg  <= '0;
    end else begin
      rel_reg <= rel_next;
      act_reg <= act_next;
      pre_reg <= pre_next;
      ms_reg  <= ms_next;
    end
  end

  assign brake_release = rel_reg;

  // low speed during the delay engages the brake on the next edge
  brake_speed_a: assert property (@(posedge mclk) disable iff (reset)
    (act_reg && !hold_release && speed_low) |=> !brake_release)
    else $error("brake not engaged after speed fell below threshold");
endmodule
`default_nettype wire

/* src/safe_torque_off_sequencer.sv */
// safe torque-off supervisor: channel filtering, monitor, alarm sequence and registers
// Summary of operation
// - monitor output on only when both channels off
// - monitor follows channel changes within 6 ms
// - either channel off forces torque-off state
// - brake engages at delay expiry or low speed
// - alarm stop sequence setting governs dynamic braking
// - channels returning under servo-on raise clearable alarm
// - clear before both channels restored raises alarm
// - after clear, servo-off sequence governs dynamic braking
// - torque-off drops ready, flags alarm, shows code
// - torque removed within 5 ms of channel off
// - off pulses under 1 ms ignored
//
// The register offsets and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module safe_torque_off_sequencer #(
  parameter int FILT_CYCLES = sto_pkg::FILTER_CYCLES,  // filter time in cycles
  parameter int MS_CYC      = sto_pkg::MS_CYCLES       // cycles per millisecond
) (
  input  wire logic                        mclk,
  input  wire logic                        reset,
  input  wire logic                        safety_channel_a,  // high while active
  input  wire logic                        safety_channel_b,  // high while active
  input  wire logic                        servo_on_in,       // servo-on command pin
  input  wire logic                        alarm_clear_in,    // alarm clear pin
  input  wire logic [15:0]                 motor_speed,       // from speed logic, same clock
  input  wire logic [sto_pkg::ADDR_W-1:0]  reg_addr,
  input  wire logic [sto_pkg::DATA_W-1:0]  reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic      [sto_pkg::DATA_W-1:0]  reg_rdata,
  output logic                             ext_device_monitor_out,
  output logic                             torque_cutoff_state,
  output logic                             torque_enable,
  output logic                             drive_ready,
  output logic                             alarm_out,
  output logic      [7:0]                  error_code,
  output logic                             brake_release_out,
  output logic                             dyn_brake_out
);
  import sto_pkg::*;

  // pin synchronisers for the command inputs
  logic              son_s1_reg;      // first stage, read only by the second
  logic              son_s2_reg;
  logic              clr_s1_reg;      // first stage, read only by the second
  logic              clr_s2_reg;
  logic              clr_prev_reg;    // edge detector on the second stage
  logic              clr_pulse;       // one cycle on a rising clear request

  // filtered channels, bit 0 is channel a
  logic [1:0]        chan_raw;
  logic [1:0]        chan_filt;
  logic              both_active;
  logic              speed_low;

  // software settings
  logic [15:0]       brake_delay_reg;
  logic [15:0]       brake_delay_next;
  logic [15:0]       speed_thr_reg;
  logic [15:0]       speed_thr_next;
  logic [SEQ_W-1:0]  alarm_seq_reg;
  logic [SEQ_W-1:0]  alarm_seq_next;
  logic [SEQ_W-1:0]  soff_seq_reg;
  logic [SEQ_W-1:0]  soff_seq_next;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;

  // supervisor state
  sup_state_t        state_reg;
  sup_state_t        state_next;
  logic [7:0]        err_reg;
  logic [7:0]        err_next;
  logic              ret_err_reg;     // channels came back under servo-on
  logic              ret_err_next;
  logic              clr_err_reg;     // clear came before channels
  logic              clr_err_next;
  logic              monitor_reg;
  logic              monitor_next;
  logic              torque_reg;
  logic              torque_next;
  logic              ready_reg;
  logic              ready_next;
  logic              db_reg;
  logic              db_next;
  logic              cut_pulse_reg;   // marks torque-off entry for the brake
  logic              cut_pulse_next;
  logic              brake_rel;

  // command pins pass two flops before anything reads them
  always_ff @(posedge mclk) begin
    if (reset) begin
      son_s1_reg   <= 1'b0;
      son_s2_reg   <= 1'b0;
      clr_s1_reg   <= 1'b0;
      clr_s2_reg   <= 1'b0;
      clr_prev_reg <= 1'b0;
    end else begin
      son_s1_reg   <= servo_on_in;
      son_s2_reg   <= son_s1_reg;
      clr_s1_reg   <= alarm_clear_in;
      clr_s2_reg   <= clr_s1_reg;
      clr_prev_reg <= clr_s2_reg;
    end
  end

  assign clr_pulse = clr_s2_reg & ~clr_prev_reg;

  // one filter per channel; the filter time keeps us inside the response limits
  assign chan_raw = {safety_channel_b, safety_channel_a};
  generate
    for (genvar gi = 0; gi < 2; gi++) begin : g_chan
      chan_filter #(
        .FILT_CYCLES (FILT_CYCLES)
      ) u_filt (
        .mclk     (mclk),
        .reset    (reset),
        .raw_in   (chan_raw[gi]),
        .filt_out (chan_filt[gi])
      );
    end
  endgenerate

  assign both_active = &chan_filt;
  assign speed_low   = motor_speed < speed_thr_reg;

  // register writes and reads; unmapped reads return zero
  always_comb begin
    brake_delay_next = brake_delay_reg;
    speed_thr_next   = speed_thr_reg;
    alarm_seq_next   = alarm_seq_reg;
    soff_seq_next    = soff_seq_reg;
    rdata_next       = '0;
    if (reg_wr) begin
      case (reg_addr)
        ADDR_BRAKE_DELAY: brake_delay_next = reg_wdata[15:0];
        ADDR_SPEED_THR:   speed_thr_next   = reg_wdata[15:0];
        ADDR_STOP_SEQ: begin
          alarm_seq_next = reg_wdata[ALM_SEQ_LSB +: SEQ_W];
          soff_seq_next  = reg_wdata[SOFF_SEQ_LSB +: SEQ_W];
        end
        default: ;  // read-only or unmapped, ignored
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        ADDR_BRAKE_DELAY: rdata_next[15:0] = brake_delay_reg;
        ADDR_SPEED_THR:   rdata_next[15:0] = speed_thr_reg;
        ADDR_STOP_SEQ: begin
          rdata_next[ALM_SEQ_LSB +: SEQ_W]  = alarm_seq_reg;
          rdata_next[SOFF_SEQ_LSB +: SEQ_W] = soff_seq_reg;
        end
        ADDR_STATUS: begin
          rdata_next[ST_CUTOFF_B]  = (state_reg == ST_CUTOFF);
          rdata_next[ST_MONITOR_B] = monitor_reg;
          rdata_next[ST_CHA_B]     = chan_filt[0];
          rdata_next[ST_CHB_B]     = chan_filt[1];
          rdata_next[ST_RETERR_B]  = ret_err_reg;
          rdata_next[ST_CLRERR_B]  = clr_err_reg;
          rdata_next[ST_READY_B]   = ready_reg;
          rdata_next[ST_BRAKE_B]   = brake_rel;
          rdata_next[ST_DB_B]      = db_reg;
        end
        ADDR_ERROR: rdata_next[7:0] = err_reg;
        default:    rdata_next = '0;
      endcase
    end
  end

  // settings and read data registers
  always_ff @(posedge mclk) begin
    if (reset) begin
      brake_delay_reg <= BRAKE_DELAY_RST;
      speed_thr_reg   <= SPEED_THR_RST;
      alarm_seq_reg   <= SEQ_RST;
      soff_seq_reg    <= SEQ_RST;
      rdata_reg       <= '0;
    end else begin
      brake_delay_reg <= brake_delay_next;
      speed_thr_reg   <= speed_thr_next;
      alarm_seq_reg   <= alarm_seq_next;
      soff_seq_reg    <= soff_seq_next;
      rdata_reg       <= rdata_next;
    end
  end

  // supervisor: torque-off entry, return checks and clear
  always_comb begin
    state_next     = state_reg;
    err_next       = err_reg;
    ret_err_next   = ret_err_reg;
    clr_err_next   = clr_err_reg;
    cut_pulse_next = 1'b0;
    unique case (state_reg)
      ST_NORMAL: begin
        if (!both_active) begin
          state_next     = ST_CUTOFF;
          err_next       = ERR_CUTOFF;
          cut_pulse_next = 1'b1;
        end
      end
      ST_CUTOFF: begin
        // servo-on stays off until the alarm is cleared
        if (clr_pulse && !both_active) begin
          clr_err_next = 1'b1;
          err_next     = ERR_CLEAR;
        end else if (clr_pulse && !son_s2_reg) begin
          state_next   = ST_NORMAL;
          err_next     = ERR_NONE;
          ret_err_next = 1'b0;
          clr_err_next = 1'b0;
        end
        // a fresh error wins over a clear in the same cycle
        if (both_active && son_s2_reg) begin
          ret_err_next = 1'b1;
          err_next     = ERR_RETURN;
          state_next   = ST_CUTOFF;
        end
      end
      default: begin
        state_next = ST_CUTOFF;  // illegal code falls to the safe state
        err_next   = ERR_CUTOFF;
      end
    endcase
    // monitor built from the filtered, synchronised channels
    monitor_next = ~chan_filt[0] & ~chan_filt[1];
    torque_next  = (state_next == ST_NORMAL) && son_s2_reg && both_active;
    ready_next   = (state_next == ST_NORMAL);
    if (state_next == ST_CUTOFF) begin
      db_next = db_for_seq(alarm_seq_reg, speed_low);
    end else if (son_s2_reg) begin
      db_next = 1'b0;
    end else begin
      db_next = db_for_seq(soff_seq_reg, speed_low);
    end
  end

  // supervisor registers
  always_ff @(posedge mclk) begin
    if (reset) begin
      state_reg     <= ST_NORMAL;
      err_reg       <= ERR_NONE;
      ret_err_reg   <= 1'b0;
      clr_err_reg   <= 1'b0;
      monitor_reg   <= 1'b0;
      torque_reg    <= 1'b0;
      ready_reg     <= 1'b0;
      db_reg        <= 1'b1;
      cut_pulse_reg <= 1'b0;
    end else begin
      state_reg     <= state_next;
      err_reg       <= err_next;
      ret_err_reg   <= ret_err_next;
      clr_err_reg   <= clr_err_next;
      monitor_reg   <= monitor_next;
      torque_reg    <= torque_next;
      ready_reg     <= ready_next;
      db_reg        <= db_next;
      cut_pulse_reg <= cut_pulse_next;
    end
  end

  // brake timing for the running case
  brake_seq #(
    .MS_CYC (MS_CYC)
  ) u_brake (
    .mclk          (mclk),
    .reset         (reset),
    .hold_release  (torque_reg),
    .cutoff_start  (cut_pulse_reg),
    .speed_low     (speed_low),
    .delay_ms      (brake_delay_reg),
    .brake_release (brake_rel)
  );

  assign reg_rdata              = rdata_reg;
  assign ext_device_monitor_out = monitor_reg;
  assign torque_cutoff_state    = (state_reg == ST_CUTOFF);
  assign torque_enable          = torque_reg;
  assign drive_ready            = ready_reg;
  assign alarm_out              = (state_reg == ST_CUTOFF);
  assign error_code             = err_reg;
  assign brake_release_out      = brake_rel;
  assign dyn_brake_out          = db_reg;

  // monitor is the registered both-off term and nothing else
  monitor_logic_a: assert property (@(posedge mclk) disable iff (reset)
    !$past(reset) |-> ext_device_monitor_out == ($past(~chan_filt[0]) && $past(~chan_filt[1])))
    else $error("monitor output disagrees with channel pair");

  // a dropped channel in normal state gives torque-off next edge
  cutoff_entry_a: assert property (@(posedge mclk) disable iff (reset)
    (state_reg == ST_NORMAL && !both_active) |=> (torque_cutoff_state && !torque_enable))
    else $error("torque-off not entered after channel drop");

  // torque never enabled while cut off or with a channel off
  torque_off_a: assert property (@(posedge mclk) disable iff (reset)
    (torque_cutoff_state || $past(!both_active)) |-> !torque_enable)
    else $error("torque enabled during torque-off");

  // entry drops ready and shows the cutoff code
  entry_flags_a: assert property (@(posedge mclk) disable iff (reset)
    $rose(torque_cutoff_state) |-> (!drive_ready && alarm_out && error_code == ERR_CUTOFF))
    else $error("torque-off entry flags wrong");

  // channels back under servo-on latch the return error and stay cut off
  return_err_a: assert property (@(posedge mclk) disable iff (reset)
    (torque_cutoff_state && both_active && son_s2_reg) |=>
      (ret_err_reg && error_code == ERR_RETURN && torque_cutoff_state))
    else $error("return under servo-on not flagged");

  // early clear latches its error and leaves the state alone
  clear_err_a: assert property (@(posedge mclk) disable iff (reset)
    (torque_cutoff_state && clr_pulse && !both_active) |=> (clr_err_reg && torque_cutoff_state))
    else $error("early alarm clear not flagged");

  // dynamic brake follows the alarm setting while cut off
  db_alarm_a: assert property (@(posedge mclk) disable iff (reset)
    ($past(state_next) == ST_CUTOFF && !$past(reset)) |->
      dyn_brake_out == db_for_seq($past(alarm_seq_reg), $past(speed_low)))
    else $error("dynamic brake not per alarm sequence");

  // after a good clear, servo-off setting governs braking
  db_servo_off_a: assert property (@(posedge mclk) disable iff (reset)
    (torque_cutoff_state && clr_pulse && both_active && !son_s2_reg) |=>
      (!torque_cutoff_state && dyn_brake_out == db_for_seq($past(soff_seq_reg), $past(speed_low))))
    else $error("servo-off braking wrong after clear");
endmodule
`default_nettype wire

/* tb/chan_source.sv */
// behavioural safety controller driving the two redundant safety channels
`timescale 1ns/1ps
`default_nettype none
module chan_source (
  input  wire logic mclk,
  output logic      ch_a,  // high while channel a is active
  output logic      ch_b   // high while channel b is active
);
  // both channels active from time zero, as a healthy controller would be
  initial begin
    ch_a = 1'b1;
    ch_b = 1'b1;
  end
  // levels change just after an edge; the caller holds an off event well past the filter
  task automatic set_ch(input logic a, input logic b);
    @(posedge mclk);
    ch_a <= a;
    ch_b <= b;
  endtask
  // self-diagnosis low pulse on channel a, kept shorter than the filter time
  task automatic diag_pulse(input int n);
    @(posedge mclk);
    ch_a <= 1'b0;
    repeat (n) @(posedge mclk);
    ch_a <= 1'b1;
  endtask
endmodule
`default_nettype wire

/* tb/testbench.sv */
// self-checking bench for the torque-off supervisor: channels, clear path, brake, registers
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import sto_pkg::*;
  localparam int FILT = 20;        // shortened filter time
  localparam int MSC  = 10;        // shortened millisecond
  localparam int TRIP = FILT + 5;  // pin change to torque-off, with margin
  logic        mclk, reset, servo_on_in, alarm_clear_in, reg_wr, reg_rd;
  logic        ch_a, ch_b, monitor, cutoff, torque, ready, alarm, brake, dynb;
  logic [15:0] motor_speed;
  logic [7:0]  reg_addr, error_code;
  logic [31:0] reg_wdata, reg_rdata;
  int          error_cnt, n_checks;

  chan_source u_chan_source (.mclk(mclk), .ch_a(ch_a), .ch_b(ch_b));

  safe_torque_off_sequencer #(.FILT_CYCLES(FILT), .MS_CYC(MSC)) u_safe_torque_off_sequencer (
    .mclk(mclk), .reset(reset), .safety_channel_a(ch_a), .safety_channel_b(ch_b),
    .servo_on_in(servo_on_in), .alarm_clear_in(alarm_clear_in), .motor_speed(motor_speed),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .ext_device_monitor_out(monitor), .torque_cutoff_state(cutoff),
    .torque_enable(torque), .drive_ready(ready), .alarm_out(alarm), .error_code(error_code),
    .brake_release_out(brake), .dyn_brake_out(dynb));

  // free-running 50 MHz clock
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // let n edges pass, then step off the edge so their updates have landed
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr    <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    #1;
    chk(reg_rdata & m, exp);
  endtask
  // clear pin held past the two-flop synchroniser, then released
  task automatic pulse_clear();
    @(posedge mclk);
    alarm_clear_in <= 1'b1;
    repeat (5) @(posedge mclk);
    alarm_clear_in <= 1'b0;
    #1;
  endtask
  // single exit point for both the normal end and the watchdog
  task automatic complete_run();
    if (error_cnt == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // watchdog: the sequence needs well under 1000 cycles
  initial begin
    #(20 * 4000);
    error_cnt++;
    complete_run();
  end

  // main sequence
  initial begin
    error_cnt = 0;
    n_checks = 0;
    reset = 1'b1;
    servo_on_in = 1'b1;
    alarm_clear_in = 1'b0;
    motor_speed = 16'h0100;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    step(4);
    rdchk(ADDR_BRAKE_DELAY, 32'h32, 32'hffffffff);
    rdchk(ADDR_SPEED_THR, 32'h1e, 32'hffffffff);
    rdchk(8'h40, 32'h0, 32'hffffffff);
    wr(ADDR_ERROR, 32'hff);
    rdchk(ADDR_ERROR, 32'h0, 32'hffffffff);
    wr(ADDR_BRAKE_DELAY, 32'h3);  // 3 ms brake delay
    wr(ADDR_STOP_SEQ, 32'h3);     // alarm: free run, servo-off: braking
    step(2);
    chk(brake, 1'b1);
    u_chan_source.diag_pulse(FILT / 2);
    step(2 * TRIP);
    chk(cutoff, 1'b0);
    u_chan_source.set_ch(1'b0, 1'b1);
    step(TRIP);
    chk(cutoff, 1'b1);
    chk(torque, 1'b0);
    chk({ready, alarm}, 2'b01);
    chk(error_code, ERR_CUTOFF);
    chk(monitor, 1'b0);
    chk(dynb, 1'b0);
    chk(brake, 1'b1);
    step(3 * MSC + 5);
    chk(brake, 1'b0);
    u_chan_source.set_ch(1'b0, 1'b0);
    step(TRIP);
    chk(monitor, 1'b1);
    rdchk(ADDR_STATUS, 32'h3, 32'hf);
    pulse_clear();
    chk(error_code, ERR_CLEAR);
    chk(cutoff, 1'b1);
    u_chan_source.set_ch(1'b1, 1'b1);
    step(TRIP);
    chk(error_code, ERR_RETURN);
    chk(monitor, 1'b0);
    @(posedge mclk);
    servo_on_in <= 1'b0;
    step(4);
    pulse_clear();
    chk({cutoff, ready}, 2'b01);
    chk(error_code, ERR_NONE);
    chk(dynb, 1'b1);
    @(posedge mclk);
    servo_on_in <= 1'b1;
    motor_speed <= 16'h0005;  // below the threshold
    step(6);
    chk({torque, brake}, 2'b11);
    u_chan_source.set_ch(1'b1, 1'b0);
    step(TRIP + 2);
    chk(cutoff, 1'b1);
    chk(brake, 1'b0);
    complete_run();
  end
endmodule
`default_nettype wire
